// >>> logic/bank_sel_pkg.sv
`default_nettype none
package bank_sel_pkg;
  localparam int NUM_BANKS = 8;
  localparam int ADDR_W = 4;

  // Register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_TARGET = 4'h4;
  localparam logic [3:0] ADDR_REMOTE = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;

  // CTRL fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CNT_LSB = 4;
  localparam int CNT_W = 3;

  // STATUS fields
  localparam int STAT_ACT_LSB = 0;
  localparam int STAT_EN_BIT = 3;
  localparam int STAT_NOTCONF_BIT = 4;
  localparam int STAT_FORCEFAIL_BIT = 5;
  localparam int STAT_PRIOFAIL_BIT = 6;
  localparam int STAT_LEVEL_LSB = 8;

  // Target and remote code field: 0 is none, 1..8 is bank 1..8
  localparam int CODE_W = 4;
  localparam logic [3:0] CODE_NONE = 4'h0;

  // Reset values
  localparam logic RST_EN = 1'b0;
  localparam logic [2:0] RST_COUNT = 3'h0;
  localparam logic [2:0] RST_ACTIVE = 3'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic not_configured;
    logic force_refused;
    logic lower_priority;
  } fail_t;
endpackage : bank_sel_pkg
`default_nettype wire

// >>> logic/parameter_bank_selector.sv
// Operation
// - Force needs configured bank and enable on
// - Enabled force selects any configured bank
// - Force released: held levels retake control
// - Read-only active bank, bank 1 after reset
// - Force target none or 1..8, pulse-like
// - Forced bank stays until another request
// - Enable defaults off, needed for changes
// - Bank count 1..8, new banks get defaults
// - Remote code none or 1..8 requests bank
// - Bank 1 held level blocks all others
// - Inputs pulse or level, priority 1 to 8
// - Held level blocks lower, higher still served
// - Pulse-selected bank holds until next request
// - Bank 8 level blocks nothing
// - Unconfigured request rejected and flagged
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module parameter_bank_selector #(
  parameter int NUM_BANKS = bank_sel_pkg::NUM_BANKS
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire bank_sel_pkg::bus_req_t BUS_REQ,
  output logic [31:0] RDATA,
  input wire logic [NUM_BANKS-1:0] BANK_REQ,
  output logic [2:0] ACTIVE_BANK,
  output logic [NUM_BANKS-1:0] BANK_ACTIVE,
  output logic [NUM_BANKS-1:0] BANK_INIT,
  output logic OVERRIDE_ON,
  output bank_sel_pkg::fail_t REQ_FAIL
);

  typedef struct packed {
    logic [NUM_BANKS-1:0] sync1;
    logic [NUM_BANKS-1:0] sync2;
    logic [NUM_BANKS-1:0] prev;
    logic override_enable;
    logic [2:0] count;
    logic [3:0] override_target;
    logic [3:0] remote_target;
    logic [2:0] active;
    logic [NUM_BANKS-1:0] active_hot;
    logic [NUM_BANKS-1:0] init_pulse;
    bank_sel_pkg::fail_t fail;
    logic [31:0] rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // Lowest index wins, so bank 1 has the highest priority
  function automatic logic [2:0] first_set(input logic [NUM_BANKS-1:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NUM_BANKS - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : first_set

  function automatic logic [NUM_BANKS-1:0] cfg_mask(input logic [2:0] cnt);
    logic [NUM_BANKS-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      m[i] = (3'(i) <= cnt);
    end
    return m;
  endfunction : cfg_mask

  function automatic logic [NUM_BANKS-1:0] above_mask(input logic [2:0] idx);
    logic [NUM_BANKS-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      m[i] = (3'(i) < idx);
    end
    return m;
  endfunction : above_mask

  logic [NUM_BANKS-1:0] cfg;
  logic [NUM_BANKS-1:0] lvl;
  logic [NUM_BANKS-1:0] lvl_prev;
  logic [NUM_BANKS-1:0] cand;
  logic [NUM_BANKS-1:0] new_cfg;
  logic [2:0] code_idx;
  logic [2:0] new_count;
  logic new_en;
  logic level_evt;
  logic wr_ctrl;
  logic wr_target;
  logic wr_remote;
  logic wr_status;
  logic code_set;
  logic code_cfg;
  bank_sel_pkg::fail_t fail_set;
  bank_sel_pkg::fail_t fail_clr;
  logic [31:0] status_word;

  always_comb begin
    s_next = s_reg;
    fail_set = '0;
    fail_clr = '0;
    cand = '0;
    s_next.sync1 = BANK_REQ;
    s_next.sync2 = s_reg.sync1;
    s_next.prev = s_reg.sync2;
    s_next.init_pulse = '0;

    wr_ctrl = BUS_REQ.wr && (BUS_REQ.addr == bank_sel_pkg::ADDR_CTRL);
    wr_target = BUS_REQ.wr && (BUS_REQ.addr == bank_sel_pkg::ADDR_TARGET);
    wr_remote = BUS_REQ.wr && (BUS_REQ.addr == bank_sel_pkg::ADDR_REMOTE);
    wr_status = BUS_REQ.wr && (BUS_REQ.addr == bank_sel_pkg::ADDR_STATUS);

    cfg = cfg_mask(s_reg.count);
    lvl = s_reg.sync2 & cfg;
    lvl_prev = s_reg.prev & cfg;
    code_set = BUS_REQ.wdata[3:0] != bank_sel_pkg::CODE_NONE;
    code_idx = 3'(BUS_REQ.wdata[3:0] - 4'h1);
    code_cfg = (BUS_REQ.wdata[3:0] <= 4'h8) && cfg[code_idx];

    // Enable stays until software clears it
    new_en = s_reg.override_enable;
    new_count = s_reg.count;
    if (wr_ctrl) begin
      new_en = BUS_REQ.wdata[bank_sel_pkg::CTRL_EN_BIT];
      new_count = BUS_REQ.wdata[bank_sel_pkg::CTRL_CNT_LSB +: 3];
    end
    new_cfg = cfg_mask(new_count);
    s_next.override_enable = new_en;
    s_next.count = new_count;
    // Freshly enabled banks are told to load default contents
    s_next.init_pulse = new_cfg & ~cfg;

    // Local inputs act on any change of held levels while the override is off; release of
    // the override also hands control back to held levels.
    level_evt = !s_reg.override_enable && (lvl != lvl_prev);
    if (s_reg.override_enable && !new_en && |lvl) begin
      level_evt = 1'b1;
    end
    if (new_en) begin
      level_evt = 1'b0;
    end
    if (level_evt && |lvl) begin
      // Highest held level wins; lower ones are blocked
      cand[first_set(lvl)] = 1'b1;
    end
    if (!s_reg.override_enable &&
        |(s_reg.sync2 & ~s_reg.prev & ~cfg)) begin
      fail_set.not_configured = 1'b1;
    end

    if (wr_target) begin
      s_next.override_target = BUS_REQ.wdata[3:0];
      if (code_set) begin
        if (!s_reg.override_enable) begin
          fail_set.force_refused = 1'b1;
        end else if (!code_cfg) begin
          fail_set.not_configured = 1'b1;
        end else begin
          // One-shot request: the bank then holds on its own
          cand[code_idx] = 1'b1;
        end
      end
    end

    if (wr_remote) begin
      s_next.remote_target = BUS_REQ.wdata[3:0];
      if (code_set) begin
        if (!s_reg.override_enable) begin
          fail_set.force_refused = 1'b1;
        end else if (!code_cfg) begin
          fail_set.not_configured = 1'b1;
        end else if (|(lvl & above_mask(code_idx))) begin
          fail_set.lower_priority = 1'b1;
        end else begin
          cand[code_idx] = 1'b1;
        end
      end
    end

    // Active bank changes only on a request and otherwise holds
    if (|cand) begin
      s_next.active = first_set(cand);
    end
    s_next.active_hot = '0;
    s_next.active_hot[s_next.active] = 1'b1;

    // Sticky failure flags, write one to clear; a set wins
    if (wr_status) begin
      fail_clr.not_configured =
        BUS_REQ.wdata[bank_sel_pkg::STAT_NOTCONF_BIT];
      fail_clr.force_refused =
        BUS_REQ.wdata[bank_sel_pkg::STAT_FORCEFAIL_BIT];
      fail_clr.lower_priority =
        BUS_REQ.wdata[bank_sel_pkg::STAT_PRIOFAIL_BIT];
    end
    s_next.fail = (s_reg.fail & ~fail_clr) | fail_set;

    status_word = '0;
    status_word[bank_sel_pkg::STAT_ACT_LSB +: 3] = s_reg.active;
    status_word[bank_sel_pkg::STAT_EN_BIT] = s_reg.override_enable;
    status_word[bank_sel_pkg::STAT_NOTCONF_BIT] = s_reg.fail.not_configured;
    status_word[bank_sel_pkg::STAT_FORCEFAIL_BIT] = s_reg.fail.force_refused;
    status_word[bank_sel_pkg::STAT_PRIOFAIL_BIT] = s_reg.fail.lower_priority;
    status_word[bank_sel_pkg::STAT_LEVEL_LSB +: NUM_BANKS] = s_reg.sync2;

    s_next.rdata = '0;
    if (BUS_REQ.rd) begin
      case (BUS_REQ.addr)
        bank_sel_pkg::ADDR_CTRL: begin
          s_next.rdata[bank_sel_pkg::CTRL_EN_BIT] = s_reg.override_enable;
          s_next.rdata[bank_sel_pkg::CTRL_CNT_LSB +: 3] = s_reg.count;
        end
        bank_sel_pkg::ADDR_TARGET: begin
          s_next.rdata[3:0] = s_reg.override_target;
        end
        bank_sel_pkg::ADDR_REMOTE: begin
          s_next.rdata[3:0] = s_reg.remote_target;
        end
        bank_sel_pkg::ADDR_STATUS: begin
          s_next.rdata = status_word;
        end
        default: begin
          s_next.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_reg <= '0;
      s_reg.override_enable <= bank_sel_pkg::RST_EN;
      s_reg.count <= bank_sel_pkg::RST_COUNT;
      s_reg.override_target <= bank_sel_pkg::CODE_NONE;
      s_reg.remote_target <= bank_sel_pkg::CODE_NONE;
      s_reg.active <= bank_sel_pkg::RST_ACTIVE;
      s_reg.active_hot <= NUM_BANKS'(1);
    end else begin
      s_reg <= s_next;
    end
  end

  assign RDATA = s_reg.rdata;
  assign ACTIVE_BANK = s_reg.active;
  assign BANK_ACTIVE = s_reg.active_hot;
  assign BANK_INIT = s_reg.init_pulse;
  assign OVERRIDE_ON = s_reg.override_enable;
  assign REQ_FAIL = s_reg.fail;

endmodule : parameter_bank_selector
`default_nettype wire

// >>> bench/bank_sel_chk.sv
`timescale 1ns/1ns
`default_nettype none
module bank_sel_chk #(
  parameter int NUM_BANKS = 8
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire bank_sel_pkg::bus_req_t BUS_REQ,
  input wire logic [31:0] RDATA,
  input wire logic [NUM_BANKS-1:0] BANK_REQ,
  input wire logic [2:0] ACTIVE_BANK,
  input wire logic [NUM_BANKS-1:0] BANK_ACTIVE,
  input wire logic [NUM_BANKS-1:0] BANK_INIT,
  input wire logic OVERRIDE_ON,
  input wire bank_sel_pkg::fail_t REQ_FAIL
);
  logic [2:0] cnt;
  logic cw;
  logic tw;
  assign cw = BUS_REQ.wr && BUS_REQ.addr == 4'h0;
  assign tw = BUS_REQ.wr && BUS_REQ.addr == 4'h4;
  // Shadow of the bank count, since it is not visible at the ports
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) cnt <= 3'h0;
    else if (cw) cnt <= BUS_REQ.wdata[6:4];
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence force_ok;
    tw && OVERRIDE_ON && BUS_REQ.wdata[3:0] != 4'h0 &&
      BUS_REQ.wdata[3:0] <= {1'b0, cnt} + 4'h1;
  endsequence
  sequence force_bad;
    tw && OVERRIDE_ON && BUS_REQ.wdata[3:0] > {1'b0, cnt} + 4'h1;
  endsequence
  chk_onehot_match: assert property (
    BANK_ACTIVE == NUM_BANKS'(1) << ACTIVE_BANK) else $error("onehot");
  chk_force_apply: assert property (force_ok |=>
    ACTIVE_BANK == $past(BUS_REQ.wdata[2:0]) - 3'h1) else $error("force");
  chk_force_unconf: assert property (force_bad |=>
    REQ_FAIL.not_configured && $stable(ACTIVE_BANK)) else $error("unconf");
  chk_force_refused: assert property (
    tw && !OVERRIDE_ON && BUS_REQ.wdata[3:0] != 4'h0 |=>
    REQ_FAIL.force_refused) else $error("refused");
  chk_enable_write: assert property (cw |=>
    OVERRIDE_ON == $past(BUS_REQ.wdata[0])) else $error("enable");
  chk_enable_holds: assert property (
    !cw |=> $stable(OVERRIDE_ON)) else $error("enable moved");
  chk_pins_ignored: assert property (
    OVERRIDE_ON && !BUS_REQ.wr |=> $stable(ACTIVE_BANK)) else $error("pins");
  chk_init_cause: assert property (|BANK_INIT |->
    $past(cw) && $past(BUS_REQ.wdata[6:4]) > $past(cnt)) else $error("init");
  chk_status_read: assert property (
    $past(BUS_REQ.rd && BUS_REQ.addr == 4'hC) |->
    RDATA[3:0] == {$past(OVERRIDE_ON), $past(ACTIVE_BANK)})
    else $error("status");
  chk_fail_sticky: assert property (
    |($past(REQ_FAIL) & ~REQ_FAIL) |->
    $past(BUS_REQ.wr && BUS_REQ.addr == 4'hC)) else $error("sticky");
endmodule : bank_sel_chk
bind parameter_bank_selector bank_sel_chk #(.NUM_BANKS(NUM_BANKS)) chk_i (
  .CLK(CLK), .RESETN(RESETN), .BUS_REQ(BUS_REQ), .RDATA(RDATA),
  .BANK_REQ(BANK_REQ), .ACTIVE_BANK(ACTIVE_BANK),
  .BANK_ACTIVE(BANK_ACTIVE), .BANK_INIT(BANK_INIT),
  .OVERRIDE_ON(OVERRIDE_ON), .REQ_FAIL(REQ_FAIL)
);
`default_nettype wire

// >>> bench/bank_req_drv.sv
`timescale 1ns/1ns
`default_nettype none
module bank_req_drv (
  input wire logic CLK,
  output logic [7:0] REQ
);
  initial REQ = 8'h00;
  // Levels stay long enough to pass the synchroniser and settle
  task automatic put(input logic [7:0] v);
    @(posedge CLK);
    REQ <= v;
    repeat (6) @(posedge CLK);
  endtask : put
endmodule : bank_req_drv
`default_nettype wire

// >>> bench/parameter_bank_selector_tb.sv
`timescale 1ns/1ns
`default_nettype none
module parameter_bank_selector_tb;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  bank_sel_pkg::bus_req_t bus = '0;
  logic [31:0] RDATA;
  logic [7:0] pins;
  logic [2:0] act;
  logic [7:0] act_hot;
  logic [7:0] init_p;
  logic ovr;
  bank_sel_pkg::fail_t fl;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  logic rd_q = 1'b0;
  logic [31:0] seed = 32'h064521A0;
  logic [31:0] k;
  logic [2:0] c;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  always #5 CLK = ~CLK;
  bank_req_drv drv (.CLK(CLK), .REQ(pins));
  parameter_bank_selector #(.NUM_BANKS(8)) dut (
    .CLK(CLK), .RESETN(RESETN), .BUS_REQ(bus), .RDATA(RDATA),
    .BANK_REQ(pins), .ACTIVE_BANK(act), .BANK_ACTIVE(act_hot),
    .BANK_INIT(init_p), .OVERRIDE_ON(ovr), .REQ_FAIL(fl)
  );
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic op(input logic [3:0] a, input logic [31:0] d,
                    input logic w);
    @(posedge CLK);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge CLK);
    bus <= '0;
  endtask : op
  task automatic rd(input logic [3:0] a, input logic [31:0] v, m);
    exp_q.push_back({v, m});
    op(a, rnd(), 1'b0);
  endtask : rd
  task automatic rs(input logic [6:0] v);
    rd(4'hC, {25'h0, v}, 32'h7F);
  endtask : rs
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      tally_and_finish();
    end
    if (rd_q) begin
      e = exp_q.pop_front();
      check_count++;
      if ((RDATA & e[31:0]) !== e[63:32]) begin
        errors++;
        $display("[ERR] RDATA exp %h got %h", e[63:32], RDATA & e[31:0]);
      end
      if (e[6:0] == 7'h7F) begin
        check_count++;
        if ({ovr, act} !== e[35:32]) begin
          errors++;
          $display("[ERR] ACTIVE_BANK exp %h got %h", e[35:32], {ovr, act});
        end
        if (act_hot !== 8'(8'h01 << e[34:32])) begin
          errors++;
          $display("[ERR] BANK_ACTIVE exp %h got %h",
                   8'(8'h01 << e[34:32]), act_hot);
        end
        if (fl !== {e[36], e[37], e[38]}) begin
          errors++;
          $display("[ERR] REQ_FAIL exp %h got %h",
                   {e[36], e[37], e[38]}, fl);
        end
        if (init_p !== 8'h00) begin
          errors++;
          $display("[ERR] BANK_INIT exp %h got %h", 8'h00, init_p);
        end
      end
    end
    rd_q <= bus.rd;
  end
  initial begin
    repeat (5) @(posedge CLK);
    RESETN <= 1'b1;
    rd(4'h0, 32'h0, 32'h71);
    rd(4'h2, 32'h0, 32'hFFFFFFFF);
    op(4'h6, rnd(), 1'b1);
    rs(7'h00);
    op(4'h4, 32'h2, 1'b1);
    rs(7'h20);
    op(4'hC, 32'h70, 1'b1);
    op(4'h0, 32'h11, 1'b1);
    op(4'h4, 32'h3, 1'b1);
    rs(7'h18);
    op(4'hC, 32'h70, 1'b1);
    op(4'h0, 32'h71, 1'b1);
    k = rnd();
    for (int i = 0; i < 8; i++) begin
      c = 3'(i + k);
      op(4'h4, 32'(c) + 32'h1, 1'b1);
      rs({4'h1, c});
    end
    op(4'h4, 32'h5, 1'b1);
    drv.put(8'h01);
    rs(7'h0C);
    op(4'h0, 32'h70, 1'b1);
    rs(7'h00);
    drv.put(8'h05);
    rs(7'h00);
    drv.put(8'h04);
    rs(7'h02);
    drv.put(8'h06);
    rs(7'h01);
    drv.put(8'h24);
    rs(7'h02);
    drv.put(8'h10);
    drv.put(8'h50);
    rs(7'h04);
    drv.put(8'h80);
    drv.put(8'h88);
    rs(7'h03);
    drv.put(8'h24);
    drv.put(8'h00);
    rs(7'h02);
    drv.put(8'h01);
    op(4'h0, 32'h71, 1'b1);
    op(4'h8, 32'h4, 1'b1);
    rs(7'h48);
    drv.put(8'h00);
    op(4'h8, 32'h6, 1'b1);
    rs(7'h4D);
    @(posedge CLK);
    RESETN <= 1'b0;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    rs(7'h00);
    tally_and_finish();
  end
endmodule : parameter_bank_selector_tb
`default_nettype wire
